// *** core/pcipm_pkg.sv ***
// Purpose: Shared constants and types for the power-management capability
//          and quadlet swap register block
// Assumes: Byte offsets within the PCI configuration header, 8-bit address
// Notes:   Capability values are fixed; only the swap bit is writable

package pcipm_pkg;

  // ==========================================================
  // Widths
  localparam int PCIPM_ADDR_W  = 8;
  localparam int PCIPM_DATA_W  = 32;
  localparam int PCIPM_BE_W    = 4;
  localparam int PCIPM_DWORD_LSB = 2;

  // ==========================================================
  // Configuration offsets (byte addresses)
  localparam logic [7:0] PCIPM_CAP_PTR_OFS   = 8'h34;
  localparam logic [7:0] PCIPM_SWAP_CTRL_OFS = 8'h40;
  localparam logic [7:0] PCIPM_CAP_HDR_OFS   = 8'h44;
  localparam logic [7:0] PCIPM_PM_CAPS_OFS   = 8'h46;

  // ==========================================================
  // Fixed register contents
  localparam logic [7:0]  PCIPM_CAP_PTR_VAL   = 8'h44;
  localparam logic [7:0]  PCIPM_CAPABILITY_CODE = 8'h01;
  localparam logic [7:0]  PCIPM_NEXT_ITEM     = 8'h00;
  localparam logic [2:0]  PCIPM_SPEC_REVISION = 3'h2;
  localparam logic [15:0] PCIPM_HDR_RESET     = 16'h0001;
  localparam logic [15:0] PCIPM_CAPS_RESET    = 16'h7e02;

  // ==========================================================
  // Swap control field layout and reset
  localparam int          PCIPM_SWAP_BIT   = 0;
  localparam logic        PCIPM_SWAP_RESET = 1'b0;
  localparam logic [30:0] PCIPM_SWAP_RSVD  = 31'h0;

  // ==========================================================
  // Power-management capabilities layout
  typedef struct packed {
    logic       wake_from_cold_off;
    logic       wake_from_hot_off;
    logic       wake_from_state_two;
    logic       wake_from_state_one;
    logic       wake_from_full_on;
    logic       state_two_supported;
    logic       state_one_supported;
    logic       dynamic_power_reporting;
    logic [1:0] reserved;
    logic       extra_init_needed;
    logic       auxiliary_supply_need;
    logic       wake_needs_bus_clock;
    logic [2:0] power_spec_revision;
  } pcipm_caps_t;

  localparam pcipm_caps_t PCIPM_CAPS_VAL = '{
    wake_from_cold_off:      1'b0,
    wake_from_hot_off:       1'b1,
    wake_from_state_two:     1'b1,
    wake_from_state_one:     1'b1,
    wake_from_full_on:       1'b1,
    state_two_supported:     1'b1,
    state_one_supported:     1'b1,
    dynamic_power_reporting: 1'b0,
    reserved:                2'h0,
    extra_init_needed:       1'b0,
    auxiliary_supply_need:   1'b0,
    wake_needs_bus_clock:    1'b0,
    power_spec_revision:     PCIPM_SPEC_REVISION
  };

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcipm_cfg_req_t;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  be;
  } pcipm_quad_t;

  // ==========================================================
  // Answer states
  typedef enum logic [1:0] {
    PCIPM_ST_IDLE   = 2'b01,
    PCIPM_ST_ANSWER = 2'b10
  } pcipm_state_t;

endpackage

// *** core/pcipm_swap.sv ***
// Purpose: Byte-order reversal of one quadlet and its byte enables
// Assumes: Combinational, used on both transfer directions
// Notes:   Pass-through when swap_en is low

`timescale 1ns/10ps
`default_nettype none

module pcipm_swap
  import pcipm_pkg::*;
(
  // Control
  input  wire logic        swap_en,
  // Quadlet
  input  wire pcipm_quad_t quad_in,
  output pcipm_quad_t      quad_out
);

  // ==========================================================
  // Lane exchange
  function automatic logic [31:0] pcipm_rev_data(input logic [31:0] d);
    pcipm_rev_data = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  function automatic logic [3:0] pcipm_rev_be(input logic [3:0] b);
    pcipm_rev_be = {b[0], b[1], b[2], b[3]};
  endfunction

  always_comb
  begin
    if (swap_en)
    begin
      quad_out.data = pcipm_rev_data(quad_in.data);
      quad_out.be   = pcipm_rev_be(quad_in.be);
    end
    else
    begin
      quad_out = quad_in;
    end
  end

endmodule

`default_nettype wire

// *** core/pcipm_regs.sv ***
// Purpose: Power-management capability registers and quadlet swap control
// Assumes: Single PCI clock domain, synchronous active-high reset,
//          configuration requests and serial memory load from same clock
// Notes:   Config reads are never swapped; data-path quadlets are

`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Swap bit reverses every quadlet, both directions
// - Swap register bits above zero read zero
// - Read-only capability item at 44h and 46h
// - Capability header low byte reads 01h
// - Next-item pointer reads 00h
// - Capabilities bit 15 reads zero
// - Capabilities bits 14 to 11 read one
// - Capabilities bits 10 and 9 read one
// - Capabilities bit 8 reads zero
// - Capabilities bits 7 and 6 read zero
// - Capabilities bit 5 reads zero
// - Capabilities bit 4 reads zero
// - Capabilities bit 3 reads zero
// - Capabilities bits 2 to 0 read 010b
// - Capability pointer at 34h reads 44h
// - Swap bit loaded from serial memory
module pcipm_regs
  import pcipm_pkg::*;
(
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           sys_rst,
  // Configuration access
  input  wire pcipm_cfg_req_t cfg_req,
  output logic [31:0]         cfg_rdata,
  output logic                cfg_ack,
  // Serial configuration memory load
  input  wire logic           rom_load_valid,
  input  wire logic           rom_swap_value,
  // Quadlets from PCI towards the core
  input  wire pcipm_quad_t    pci_in,
  input  wire logic           pci_in_valid,
  output pcipm_quad_t         core_out,
  output logic                core_out_valid,
  // Quadlets from the core towards PCI
  input  wire pcipm_quad_t    core_in,
  input  wire logic           core_in_valid,
  output pcipm_quad_t         pci_out,
  output logic                pci_out_valid,
  // Status
  output logic                swap_active
);

  // ==========================================================
  // Address decode
  function automatic logic pcipm_hit(input logic [7:0] a, input logic [7:0] ofs);
    pcipm_hit = (a[7:PCIPM_DWORD_LSB] == ofs[7:PCIPM_DWORD_LSB]);
  endfunction

  // ==========================================================
  // Read value of one configuration dword
  function automatic logic [31:0] pcipm_read(input logic [7:0] a, input logic sw);
    logic [31:0] v;
    v = 32'h0;
    if (pcipm_hit(a, PCIPM_CAP_PTR_OFS))
      v = {24'h0, PCIPM_CAP_PTR_VAL};
    else if (pcipm_hit(a, PCIPM_SWAP_CTRL_OFS))
      v = {PCIPM_SWAP_RSVD, sw};
    else if (pcipm_hit(a, PCIPM_CAP_HDR_OFS))
      // wake from hot, two, one, on
      v = {PCIPM_CAPS_VAL, PCIPM_NEXT_ITEM, PCIPM_CAPABILITY_CODE};
    pcipm_read = v;
  endfunction

  // ==========================================================
  // Configuration answer and swap bit
  pcipm_state_t state;
  pcipm_state_t next_state;
  logic         swap_bit;
  logic         next_swap_bit;
  logic [31:0]  next_cfg_rdata;
  logic         next_cfg_ack;

  always_comb
  begin
    next_state     = state;
    next_swap_bit  = swap_bit;
    next_cfg_rdata = cfg_rdata;
    next_cfg_ack   = 1'b0;
    case (state)
      PCIPM_ST_IDLE:
      begin
        if (cfg_req.valid)
        begin
          next_state   = PCIPM_ST_ANSWER;
          next_cfg_ack = 1'b1;
          if (cfg_req.write)
          begin
            next_cfg_rdata = 32'h0;
            if (pcipm_hit(cfg_req.addr, PCIPM_SWAP_CTRL_OFS) && cfg_req.be[0])
              next_swap_bit = cfg_req.wdata[PCIPM_SWAP_BIT];
          end
          else
          begin
            next_cfg_rdata = pcipm_read(cfg_req.addr, swap_bit);
          end
        end
      end
      PCIPM_ST_ANSWER:
      begin
        next_state = PCIPM_ST_IDLE;
      end
      default:
      begin
        next_state = PCIPM_ST_IDLE;
      end
    endcase
    if (rom_load_valid)
      next_swap_bit = rom_swap_value;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state     <= PCIPM_ST_IDLE;
      swap_bit  <= PCIPM_SWAP_RESET;
      cfg_rdata <= 32'h0;
      cfg_ack   <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      swap_bit  <= next_swap_bit;
      cfg_rdata <= next_cfg_rdata;
      cfg_ack   <= next_cfg_ack;
    end
  end

  // ==========================================================
  // Quadlet data path
  pcipm_quad_t swapped_in;
  pcipm_quad_t swapped_out;

  pcipm_swap u_swap_in
  (
    .swap_en  (swap_bit),
    .quad_in  (pci_in),
    .quad_out (swapped_in)
  );

  pcipm_swap u_swap_out
  (
    .swap_en  (swap_bit),
    .quad_in  (core_in),
    .quad_out (swapped_out)
  );

  pcipm_quad_t next_core_out;
  pcipm_quad_t next_pci_out;
  logic        next_core_out_valid;
  logic        next_pci_out_valid;

  always_comb
  begin
    next_core_out       = pci_in_valid ? swapped_in : core_out;
    next_pci_out        = core_in_valid ? swapped_out : pci_out;
    next_core_out_valid = pci_in_valid;
    next_pci_out_valid  = core_in_valid;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      core_out       <= '0;
      pci_out        <= '0;
      core_out_valid <= 1'b0;
      pci_out_valid  <= 1'b0;
      swap_active    <= PCIPM_SWAP_RESET;
    end
    else
    begin
      core_out       <= next_core_out;
      pci_out        <= next_pci_out;
      core_out_valid <= next_core_out_valid;
      pci_out_valid  <= next_pci_out_valid;
      swap_active    <= next_swap_bit;
    end
  end

endmodule

`default_nettype wire

// *** verif/pcipm_host.sv ***
// Purpose: Host model issuing configuration reads and writes
// Assumes: Answer comes one cycle after the request is taken
// Notes:   Released request lines: valid and write low, address, enables and data inverted
`timescale 1ns/10ps
`default_nettype none
module pcipm_host
  import pcipm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        cfg_ack,
  input  wire logic [31:0] cfg_rdata,
  output var pcipm_cfg_req_t cfg_req
);
  int timeouts = 0;
  initial cfg_req = '0;
  // ==========================================
  // One configuration access, held through the answer cycle
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(negedge ref_clk);
    cfg_req = '{1'b1, w, a, b, d};
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (cfg_ack !== 1'b1 && n < 8);
    if (cfg_ack !== 1'b1)
      timeouts++;
    r = cfg_rdata;
    @(negedge ref_clk);
    cfg_req = {1'b0, ~cfg_req[43:0]};
  endtask
endmodule
`default_nettype wire

// *** verif/pcipm_regs_asserts.sv ***
// Purpose: Port checker for capability reads and quadlet swap
// Assumes: One clock, synchronous reset
// Notes:   Bound to pcipm_regs
`timescale 1ns/10ps
`default_nettype none
module pcipm_regs_asserts
  import pcipm_pkg::*;
(
  input wire logic           ref_clk,
  input wire logic           sys_rst,
  input wire pcipm_cfg_req_t cfg_req,
  input wire logic [31:0]    cfg_rdata,
  input wire logic           cfg_ack,
  input wire logic           rom_load_valid,
  input wire logic           rom_swap_value,
  input wire pcipm_quad_t    pci_in,
  input wire logic           pci_in_valid,
  input wire pcipm_quad_t    core_out,
  input wire logic           core_out_valid,
  input wire pcipm_quad_t    core_in,
  input wire logic           core_in_valid,
  input wire pcipm_quad_t    pci_out,
  input wire logic           pci_out_valid,
  input wire logic           swap_active
);
  function automatic pcipm_quad_t rev(pcipm_quad_t q);
    return {q.data[7:0], q.data[15:8], q.data[23:16], q.data[31:24], q.be[0], q.be[1], q.be[2], q.be[3]};
  endfunction
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence rd_s(logic [5:0] a);
    cfg_req.valid && !cfg_ack && !cfg_req.write && cfg_req.addr[7:2] == a;
  endsequence
  sequence wr_swap_s;
    cfg_req.valid && !cfg_ack && cfg_req.write && cfg_req.addr[7:2] == 6'h10 && cfg_req.be[0] && !rom_load_valid;
  endsequence
  // ==========================================
  // Assertions
  ack_latency_a: assert property (cfg_req.valid && !cfg_ack |=> cfg_ack)
    else $error("config answer late");
  ack_pulse_a: assert property (cfg_ack |=> !cfg_ack)
    else $error("config answer too long");
  cap_item_a: assert property (rd_s(6'h11) |=> cfg_rdata == 32'h7e020001)
    else $error("capability item wrong");
  cap_ptr_a: assert property (rd_s(6'h0d) |=> cfg_rdata == 32'h00000044)
    else $error("capability pointer wrong");
  swap_rsvd_a: assert property (rd_s(6'h10) |=> cfg_rdata[31:1] == 31'h0)
    else $error("swap reserved bits set");
  swap_up_a: assert property (pci_in_valid && swap_active |=> core_out_valid && core_out == rev($past(pci_in)))
    else $error("inbound quadlet not swapped");
  pass_up_a: assert property (pci_in_valid && !swap_active |=> core_out_valid && core_out == $past(pci_in))
    else $error("inbound quadlet altered");
  swap_dn_a: assert property (core_in_valid && swap_active |=> pci_out_valid && pci_out == rev($past(core_in)))
    else $error("outbound quadlet not swapped");
  rom_load_a: assert property (rom_load_valid |=> swap_active == $past(rom_swap_value))
    else $error("swap bit not loaded");
  pass_dn_a: assert property (core_in_valid && !swap_active |=> pci_out_valid && pci_out == $past(core_in))
    else $error("outbound quadlet altered");
  swap_write_a: assert property (wr_swap_s |=> swap_active == $past(cfg_req.wdata[0]))
    else $error("swap bit not written");
endmodule
bind pcipm_regs pcipm_regs_asserts u_chk (.ref_clk, .sys_rst, .cfg_req, .cfg_rdata, .cfg_ack, .rom_load_valid,
  .rom_swap_value, .pci_in, .pci_in_valid, .core_out, .core_out_valid, .core_in, .core_in_valid, .pci_out,
  .pci_out_valid, .swap_active);
`default_nettype wire

// *** verif/pcipm_regs_test.sv ***
// Purpose: Self-checking bench for pcipm_regs
// Assumes: Inputs driven at the falling edge
// Notes:   Quadlet model runs on queues
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module pcipm_regs_test;
  import pcipm_pkg::*;
  logic           ref_clk;
  logic           sys_rst;
  logic           rom_load_valid;
  logic           rom_swap_value;
  logic           pci_in_valid;
  logic           core_in_valid;
  logic           cfg_ack;
  logic           core_out_valid;
  logic           pci_out_valid;
  logic           swap_active;
  logic [31:0]    cfg_rdata;
  logic [31:0]    rd;
  pcipm_cfg_req_t cfg_req;
  pcipm_quad_t    pci_in;
  pcipm_quad_t    core_in;
  pcipm_quad_t    core_out;
  pcipm_quad_t    pci_out;
  pcipm_quad_t    q_up[$];
  pcipm_quad_t    q_dn[$];
  int             num_errors;
  int             checks_done;
  int             sw;
  logic [7:0]     addrs[5] = '{8'h34, 8'h44, 8'h46, 8'h40, 8'h48};
  logic [31:0]    exps[5] = '{32'h00000044, 32'h7e020001, 32'h7e020001, 32'h0, 32'h0};
  pcipm_regs u_dut (.ref_clk, .sys_rst, .cfg_req, .cfg_rdata, .cfg_ack, .rom_load_valid, .rom_swap_value,
    .pci_in, .pci_in_valid, .core_out, .core_out_valid, .core_in, .core_in_valid, .pci_out, .pci_out_valid,
    .swap_active);
  pcipm_host u_host (.ref_clk, .cfg_ack, .cfg_rdata, .cfg_req);
  initial
  begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  function automatic pcipm_quad_t model(pcipm_quad_t q);
    if (sw == 0)
      return q;
    return {q.data[7:0], q.data[15:8], q.data[23:16], q.data[31:24], q.be[0], q.be[1], q.be[2], q.be[3]};
  endfunction
  // ==========================================
  // Result monitor
  always @(negedge ref_clk)
  begin
    pcipm_quad_t e;
    if (core_out_valid === 1'b1)
    begin
      e = q_up.size() ? q_up.pop_front() : 'x;
      `CHK("core_out", e, core_out)
    end
    if (pci_out_valid === 1'b1)
    begin
      e = q_dn.size() ? q_dn.pop_front() : 'x;
      `CHK("pci_out", e, pci_out)
    end
  end
  task automatic traffic(input int n);
    repeat (n)
    begin
      @(negedge ref_clk);
      pci_in = {$urandom, 4'($urandom)};
      core_in = {$urandom, 4'($urandom)};
      pci_in_valid = 1'($urandom);
      core_in_valid = 1'($urandom);
      if (pci_in_valid)
        q_up.push_back(model(pci_in));
      if (core_in_valid)
        q_dn.push_back(model(core_in));
    end
    @(negedge ref_clk);
    pci_in_valid = 0;
    core_in_valid = 0;
  endtask
  task automatic rom_load(input logic v);
    @(negedge ref_clk);
    rom_load_valid = 1;
    rom_swap_value = v;
    @(negedge ref_clk);
    rom_load_valid = 0;
    sw = v;
    `CHK("swap_active", v, swap_active)
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #20000;
    num_errors++;
    finish_test();
  end
  initial
  begin
    void'($urandom(92));
    sys_rst = 1;
    rom_load_valid = 0;
    rom_swap_value = 0;
    pci_in = '0;
    core_in = '0;
    pci_in_valid = 0;
    core_in_valid = 0;
    sw = 0;
    repeat (8) @(negedge ref_clk);
    sys_rst = 0;
    foreach (addrs[i])
    begin
      u_host.cfg(1'b0, addrs[i], 4'($urandom), 32'h0, rd);
      `CHK("cfg_rdata", exps[i], rd)
    end
    $display("test reads done");
    u_host.cfg(1'b1, 8'h44, 4'hf, 32'hffffffff, rd);
    `CHK("write_rdata", 32'h0, rd)
    u_host.cfg(1'b1, 8'h40, 4'hf, 32'hffffffff, rd);
    sw = 1;
    `CHK("swap_active", 1'b1, swap_active)
    u_host.cfg(1'b1, 8'h40, 4'he, 32'h0, rd);
    `CHK("swap_active", 1'b1, swap_active)
    u_host.cfg(1'b0, 8'h44, 4'hf, 32'h0, rd);
    `CHK("cap_item", 32'h7e020001, rd)
    u_host.cfg(1'b0, 8'h40, 4'hf, 32'h0, rd);
    `CHK("swap_ctrl", 32'h00000001, rd)
    traffic(200);
    $display("test swapped traffic done");
    rom_load(1'b0);
    traffic(150);
    rom_load(1'b1);
    traffic(100);
    repeat (2) @(negedge ref_clk);
    `CHK("quads_left", 0, q_up.size() + q_dn.size())
    `CHK("host_timeouts", 0, u_host.timeouts)
    $display("test serial load done");
    finish_test();
  end
endmodule
`default_nettype wire
